// file: fpg_pkg.sv
// Shared constants for the flash program/erase guard
package fpg_pkg;

    // Bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned EBS_W = 8;
    localparam int unsigned IRQ_W = 3;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] FC1_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] FC2_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] EBS_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] STAT_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] IRQ_CLR_OFS = 8'h14;
    localparam logic [ADDR_W-1:0] IRQ_EN_OFS = 8'h18;

    // flash_control_one fields
    localparam int unsigned FC1_PROG_BIT = 0;
    localparam int unsigned FC1_ERASE_BIT = 1;
    localparam int unsigned FC1_WREN_BIT = 6;

    // flash_control_two fields
    localparam int unsigned FC2_ERR_BIT = 7;

    // Status register fields
    localparam int unsigned STAT_PROG_BIT = 0;
    localparam int unsigned STAT_ERASE_BIT = 1;
    localparam int unsigned STAT_ERRSTATE_BIT = 2;
    localparam int unsigned STAT_LOWPOW_BIT = 3;

    // Interrupt status, clear and enable fields
    localparam int unsigned IRQ_DONE_BIT = 0;
    localparam int unsigned IRQ_ERR_BIT = 1;
    localparam int unsigned IRQ_HWP_BIT = 2;

    // Reset values
    localparam logic [EBS_W-1:0] EBS_RST = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Operating modes of the guard
    typedef enum logic [1:0] {
        MODE_IDLE,
        MODE_PROG,
        MODE_ERASE,
        MODE_ERROR
    } fpg_mode_t;

endpackage

// file: fpg_sticky.sv
// Sticky event flags where a set wins over a clear
`timescale 1ns/1ps
module fpg_sticky #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input logic clock,
    input logic srst,
    // Events and software clears
    input logic [W-1:0] set,
    input logic [W-1:0] clr,
    // Held flags
    output logic [W-1:0] flags
);
    typedef struct packed {
        logic [W-1:0] flags;
    } fpg_sticky_t;

    fpg_sticky_t q;
    fpg_sticky_t d;

    always_comb
    begin
        d = q;
        d.flags = (q.flags & ~clr) | set;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            q <= '0;
        else
            q <= d;
    end

    assign flags = q.flags;
endmodule

// file: fpg_edge.sv
// Rising edge detector for a group of level inputs
`timescale 1ns/1ps
module fpg_edge #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input logic clock,
    input logic srst,
    // Levels in, one-cycle pulses out
    input logic [W-1:0] lvl,
    output logic [W-1:0] rise
);
    typedef struct packed {
        logic [W-1:0] prev;
        logic [W-1:0] rise;
    } fpg_edge_t;

    fpg_edge_t q;
    fpg_edge_t d;

    always_comb
    begin
        d = q;
        d.prev = lvl;
        d.rise = lvl & ~q.prev;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            q <= '0;
        else
            q <= d;
    end

    assign rise = q.rise;
endmodule

// file: fpg_guard.sv
// Flash program/erase guard with AXI4-Lite registers
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
// Summary of operation
// - Reset or low-power entry aborts and refuses operations
// - Low-power entry reinitialises control and block-select registers
// - Cleared write enable blocks program and erase
// - Erase only selected blocks; zero mask protects all
// - Protection error sets error flag and aborts
// - Flash read during operation is protection error
// - Non-reset exception during operation is protection error
// - Sleep instruction during operation is protection error
module fpg_guard (
    // Clock and reset
    input logic clock,
    input logic srst,
    // AXI4-Lite write address and data
    input logic awvalid,
    output logic awready,
    input logic [fpg_pkg::ADDR_W-1:0] awaddr,
    input logic [2:0] awprot,
    input logic wvalid,
    output logic wready,
    input logic [fpg_pkg::DATA_W-1:0] wdata,
    input logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input logic arvalid,
    output logic arready,
    input logic [fpg_pkg::ADDR_W-1:0] araddr,
    input logic [2:0] arprot,
    output logic rvalid,
    input logic rready,
    output logic [fpg_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    // Power mode levels from the power controller
    input logic lp_subactive,
    input logic lp_subsleep,
    input logic lp_standby,
    // CPU activity seen during an operation
    input logic flash_rd,
    input logic exc_start,
    input logic sleep_exec,
    // Flash array control
    output logic flash_prog,
    output logic flash_erase,
    output logic [fpg_pkg::EBS_W-1:0] flash_erase_blocks,
    output logic flash_error,
    // Interrupt
    output logic irq
);
    import fpg_pkg::*;

    typedef struct packed {
        fpg_mode_t mode;
        logic wren;
        logic [EBS_W-1:0] ebs;
        logic err_flag;
        logic [IRQ_W-1:0] irq_en;
        logic irq;
        logic prog;
        logic erase;
        logic [EBS_W-1:0] erase_blocks;
        logic done_ev;
        logic err_ev;
        logic aw_got;
        logic [ADDR_W-1:0] awaddr;
        logic w_got;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } fpg_state_t;

    fpg_state_t q;
    fpg_state_t d;

    logic lowpower;
    logic busy;
    logic fault;
    logic wr_fire;
    logic wr_hit;
    logic fc1_wr;
    logic [7:0] wd;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic [IRQ_W-1:0] irq_flags;
    logic [2:0] lp_rise;

    // Low-power entry is reported once, even if the level stays high
    fpg_edge #(
        .W(3)
    ) u_lp_edge (
        .clock(clock),
        .srst(srst),
        .lvl({lp_standby, lp_subsleep, lp_subactive}),
        .rise(lp_rise)
    );

    fpg_sticky #(
        .W(IRQ_W)
    ) u_irq_flags (
        .clock(clock),
        .srst(srst),
        .set(irq_set),
        .clr(irq_clr),
        .flags(irq_flags)
    );

    always_comb
    begin
        irq_set = '0;
        irq_set[IRQ_DONE_BIT] = q.done_ev;
        irq_set[IRQ_ERR_BIT] = q.err_ev;
        irq_set[IRQ_HWP_BIT] = |lp_rise;
    end

    assign lowpower = lp_subactive | lp_subsleep | lp_standby;
    assign busy = (q.mode == MODE_PROG) || (q.mode == MODE_ERASE);
    // Any flash read while busy counts, since software must run from RAM
    assign fault = busy && (flash_rd || exc_start || sleep_exec);
    assign wr_fire = q.aw_got && q.w_got;
    assign wr_hit = wr_fire && q.wstrb[0];
    assign wd = q.wdata[7:0];
    assign fc1_wr = wr_hit && (q.awaddr == FC1_OFS);
    assign irq_clr = (wr_hit && (q.awaddr == IRQ_CLR_OFS)) ? wd[IRQ_W-1:0] : '0;

    always_comb
    begin
        d = q;
        d.done_ev = 1'b0;
        d.err_ev = 1'b0;

        // Address and data are taken independently, in either order
        if (awvalid && q.awready)
        begin
            d.aw_got = 1'b1;
            d.awaddr = awaddr;
        end
        if (wvalid && q.wready)
        begin
            d.w_got = 1'b1;
            d.wdata = wdata;
            d.wstrb = wstrb;
        end
        if (q.bvalid && bready)
            d.bvalid = 1'b0;
        if (wr_fire)
        begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            unique case (q.awaddr)
                FC1_OFS, FC2_OFS, EBS_OFS, STAT_OFS, IRQ_STAT_OFS, IRQ_CLR_OFS, IRQ_EN_OFS:
                    d.bresp = RESP_OKAY;
                default:
                    d.bresp = RESP_SLVERR;
            endcase
        end

        // Plain register writes
        if (wr_hit && (q.awaddr == IRQ_EN_OFS))
            d.irq_en = wd[IRQ_W-1:0];
        // Mask is frozen while erasing so the erased set cannot change mid-pulse
        if (wr_hit && (q.awaddr == EBS_OFS) && !busy)
            d.ebs = wd;
        if (fc1_wr)
            d.wren = wd[FC1_WREN_BIT];

        // Mode sequencing; entry needs write enable already set
        unique case (q.mode)
            MODE_IDLE:
            begin
                // A write that drops write enable cannot also start an operation
                if (fc1_wr && q.wren && wd[FC1_WREN_BIT] && !lowpower)
                begin
                    if (wd[FC1_PROG_BIT] && !wd[FC1_ERASE_BIT])
                        d.mode = MODE_PROG;
                    else if (wd[FC1_ERASE_BIT] && !wd[FC1_PROG_BIT] && (q.ebs != '0))
                        d.mode = MODE_ERASE;
                end
            end
            MODE_PROG:
            begin
                if (fc1_wr && (!wd[FC1_PROG_BIT] || !wd[FC1_WREN_BIT]))
                begin
                    d.mode = MODE_IDLE;
                    d.done_ev = 1'b1;
                end
            end
            MODE_ERASE:
            begin
                if (fc1_wr && (!wd[FC1_ERASE_BIT] || !wd[FC1_WREN_BIT]))
                begin
                    d.mode = MODE_IDLE;
                    d.done_ev = 1'b1;
                end
            end
            MODE_ERROR:
                d.mode = MODE_ERROR;
        endcase

        // Protection error aborts at once and locks out further operations
        if (fault)
        begin
            d.mode = MODE_ERROR;
            d.err_flag = 1'b1;
            d.err_ev = 1'b1;
            d.done_ev = 1'b0;
        end

        // Hardware protection overrides any control or block-select write in the same cycle
        if (lowpower)
        begin
            d.wren = 1'b0;
            d.ebs = EBS_RST;
            if (d.mode != MODE_ERROR)
                d.mode = MODE_IDLE;
            d.done_ev = 1'b0;
        end

        // Read channel
        if (q.rvalid && rready)
            d.rvalid = 1'b0;
        if (arvalid && q.arready)
        begin
            d.rvalid = 1'b1;
            d.rdata = '0;
            d.rresp = RESP_OKAY;
            unique case (araddr)
                FC1_OFS:
                begin
                    d.rdata[FC1_WREN_BIT] = q.wren;
                    d.rdata[FC1_ERASE_BIT] = q.erase;
                    d.rdata[FC1_PROG_BIT] = q.prog;
                end
                FC2_OFS:
                    d.rdata[FC2_ERR_BIT] = q.err_flag;
                EBS_OFS:
                    d.rdata[EBS_W-1:0] = q.ebs;
                STAT_OFS:
                begin
                    d.rdata[STAT_PROG_BIT] = q.prog;
                    d.rdata[STAT_ERASE_BIT] = q.erase;
                    d.rdata[STAT_ERRSTATE_BIT] = (q.mode == MODE_ERROR);
                    d.rdata[STAT_LOWPOW_BIT] = lowpower;
                end
                IRQ_STAT_OFS:
                    d.rdata[IRQ_W-1:0] = irq_flags;
                IRQ_CLR_OFS:
                    d.rdata = '0;
                IRQ_EN_OFS:
                    d.rdata[IRQ_W-1:0] = q.irq_en;
                default:
                    d.rresp = RESP_SLVERR;
            endcase
        end

        // Flash outputs follow the next mode so they leave the flop in step with it
        d.prog = (d.mode == MODE_PROG);
        d.erase = (d.mode == MODE_ERASE);
        d.erase_blocks = (d.mode == MODE_ERASE) ? d.ebs : '0;
        d.irq = |(irq_flags & q.irq_en);
        d.awready = !d.aw_got && !d.bvalid;
        d.wready = !d.w_got && !d.bvalid;
        d.arready = !d.rvalid;
    end

    // Reset is the chip reset: it aborts and clears everything
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            q <= '0;
            q.mode <= MODE_IDLE;
            q.ebs <= EBS_RST;
            q.irq_en <= IRQ_EN_RST;
            q.bresp <= RESP_OKAY;
            q.rresp <= RESP_OKAY;
        end
        else
            q <= d;
    end

    assign awready = q.awready;
    assign wready = q.wready;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = q.arready;
    assign rvalid = q.rvalid;
    assign rdata = q.rdata;
    assign rresp = q.rresp;
    assign flash_prog = q.prog;
    assign flash_erase = q.erase;
    assign flash_erase_blocks = q.erase_blocks;
    assign flash_error = q.err_flag;
    assign irq = q.irq;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    a_lowpow_abort: assert property (lowpower |=> !flash_prog && !flash_erase)
        else $error("operation survived low-power entry");
    a_lowpow_init: assert property (lowpower |=> (q.wren == 1'b0) && (q.ebs == EBS_RST))
        else $error("registers not reinitialised on low-power entry");
    a_wren_blocks: assert property ($rose(flash_prog) || $rose(flash_erase) |-> $past(q.wren))
        else $error("operation started without write enable");
    a_erase_mask: assert property ($rose(flash_erase) |-> ($past(q.ebs) != '0) && (flash_erase_blocks != '0))
        else $error("erase started with no block selected");
    a_error_abort: assert property (fault |=> flash_error && !flash_prog && !flash_erase ##1 irq_flags[IRQ_ERR_BIT])
        else $error("protection error did not abort and flag");
    a_read_error: assert property ((flash_prog || flash_erase) && flash_rd |=> flash_error)
        else $error("flash read during operation not flagged");
    a_exc_error: assert property ((flash_prog || flash_erase) && exc_start |=> q.mode == MODE_ERROR)
        else $error("exception during operation not flagged");
    a_sleep_error: assert property ((flash_prog || flash_erase) && sleep_exec |=> flash_error)
        else $error("sleep during operation not flagged");
    a_error_holds: assert property (flash_error |=> flash_error && !flash_prog && !flash_erase)
        else $error("error state left without reset");
    a_write_resp: assert property (q.aw_got && q.w_got |=> bvalid && !awready && !wready)
        else $error("write response not issued");
    a_irq_level: assert property (|(irq_flags & q.irq_en) |=> irq)
        else $error("enabled status did not raise interrupt");

    c_prog_done: cover property ($rose(flash_prog) ##[1:50] $fell(flash_prog) && !flash_error);
    c_erase_run: cover property ($rose(flash_erase));
    c_error_hit: cover property ($rose(flash_error));
    c_hw_abort: cover property ((flash_prog || flash_erase) && lowpower);
endmodule

// file: fpg_cpu_model.sv
// CPU-side model that makes flash reads and exception events
`timescale 1ns/1ps
module fpg_cpu_model (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Commands from the test sequence
    input wire logic rom_run,
    input wire logic go,
    input wire logic [1:0] kind,
    // Activity seen by the guard
    output logic flash_rd,
    output logic exc_start,
    output logic sleep_exec
);
    logic fetch_q;
    always_ff @(posedge clock)
    begin
        if (srst)
            fetch_q <= 1'b0;
        else
            fetch_q <= ~fetch_q;
    end
    // Fetches stop once control runs from RAM; only a commanded fault reads flash then
    assign flash_rd = (rom_run & fetch_q) | (go & (kind == 2'h0));
    assign exc_start = go & (kind == 2'h1);
    assign sleep_exec = go & (kind == 2'h2);
endmodule

// file: tb_fpg_guard.sv
// Self-checking bench for the flash program/erase guard
`timescale 1ns/1ps
module tb_fpg_guard;
    import fpg_pkg::*;
    localparam logic [31:0] WEN = 32'h40;
    localparam logic [31:0] PRG = 32'h41;
    localparam logic [31:0] ERS = 32'h42;
    logic clock, srst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, go, rom_run;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata, v;
    logic [1:0] bresp, rresp, rsp, kind;
    logic [2:0] lp;
    logic flash_rd, exc_start, sleep_exec, flash_prog, flash_erase, flash_error, irq;
    logic [EBS_W-1:0] flash_erase_blocks;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;

    fpg_guard fpg_guard_i (
        .clock(clock), .srst(srst), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .lp_subactive(lp[0]),
        .lp_subsleep(lp[1]), .lp_standby(lp[2]), .flash_rd(flash_rd), .exc_start(exc_start),
        .sleep_exec(sleep_exec), .flash_prog(flash_prog), .flash_erase(flash_erase),
        .flash_erase_blocks(flash_erase_blocks), .flash_error(flash_error), .irq(irq)
    );

    fpg_cpu_model fpg_cpu_model_i (
        .clock(clock), .srst(srst), .rom_run(rom_run), .go(go), .kind(kind),
        .flash_rd(flash_rd), .exc_start(exc_start), .sleep_exec(sleep_exec)
    );

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic end_of_test;
        if (n_fail == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Generous ceiling; the whole sequence needs well under a thousand cycles
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 8000)
        begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic rst;
        srst <= 1'b1;
        tick(5);
        srst <= 1'b0;
        tick(1);
    endtask

    // Address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        @(posedge clock);
        ta = 1'b0;
        tw = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clock);
            ta |= awready;
            tw |= wready;
            awvalid <= !ta;
            wvalid <= !tw;
        end
        while (!(ta && tw));
        while (!bvalid)
            @(posedge clock);
        rsp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
            @(posedge clock);
        while (!arready);
        arvalid <= 1'b0;
        do
            @(posedge clock);
        while (!rvalid);
        d = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask

    task automatic start(input logic [31:0] d);
        wr(FC1_OFS, WEN);
        wr(FC1_OFS, d);
    endtask

    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready, go} = 6'h0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        kind = 2'h0;
        lp = 3'h0;
        rom_run = 1'b1;
        rst();
        rd(FC1_OFS, v);
        chk("fc1", v, 32'h0);
        rd(FC2_OFS, v);
        chk("fc2", v, 32'h0);
        rd(EBS_OFS, v);
        chk("ebs", v, 32'(EBS_RST));
        rd(8'h1c, v);
        chk("rresp", 32'(rsp), 32'(RESP_SLVERR));
        wr(8'h1c, 32'h0);
        chk("bresp", 32'(rsp), 32'(RESP_SLVERR));
        // Reads while idle are ordinary fetches, not faults
        chk("err", 32'(flash_error), 32'h0);
        rom_run <= 1'b0;
        wr(FC1_OFS, 32'h01);
        chk("prog", 32'(flash_prog), 32'h0);
        wr(FC1_OFS, 32'h02);
        chk("ers", 32'(flash_erase), 32'h0);
        wr(FC1_OFS, PRG);
        chk("prog", 32'(flash_prog), 32'h0);
        wr(IRQ_EN_OFS, 32'h1);
        start(PRG);
        chk("prog", 32'(flash_prog), 32'h1);
        rd(FC1_OFS, v);
        chk("fc1", v, 32'h41);
        wr(FC1_OFS, WEN);
        tick(3);
        chk("prog", 32'(flash_prog), 32'h0);
        chk("irq", 32'(irq), 32'h1);
        wr(IRQ_EN_OFS, 32'h0);
        tick(2);
        chk("irq", 32'(irq), 32'h0);
        wr(IRQ_CLR_OFS, 32'h1);
        rd(IRQ_STAT_OFS, v);
        chk("ist", v, 32'h0);
        wr(FC1_OFS, ERS);
        chk("ers", 32'(flash_erase), 32'h0);
        wr(EBS_OFS, 32'ha5);
        wr(FC1_OFS, ERS);
        chk("ers", 32'(flash_erase), 32'h1);
        chk("blk", 32'(flash_erase_blocks), 32'ha5);
        wr(FC1_OFS, WEN);
        chk("blk", 32'(flash_erase_blocks), 32'h0);
        for (int k = 0; k < 3; k++)
        begin
            wr(EBS_OFS, 32'h3c);
            start(PRG);
            lp <= 3'h1 << k;
            tick(2);
            chk("prog", 32'(flash_prog), 32'h0);
            start(PRG);
            chk("prog", 32'(flash_prog), 32'h0);
            rd(FC1_OFS, v);
            chk("fc1", v, 32'h0);
            rd(EBS_OFS, v);
            chk("ebs", v, 32'h0);
            rd(STAT_OFS, v);
            chk("stat", v, 32'h8);
            rd(IRQ_STAT_OFS, v);
            chk("ist", v, 32'h5);
            lp <= 3'h0;
        end
        start(PRG);
        for (int k = 0; k < 3; k++)
        begin
            // Only a reset leaves the error state, so each fault kind starts fresh
            rst();
            chk("prog", 32'(flash_prog), 32'h0);
            chk("err", 32'(flash_error), 32'h0);
            wr(IRQ_EN_OFS, 32'h2);
            wr(EBS_OFS, 32'h81);
            start((k == 2) ? ERS : PRG);
            kind <= 2'(k);
            go <= 1'b1;
            tick(1);
            go <= 1'b0;
            tick(3);
            chk("busy", 32'(flash_prog | flash_erase), 32'h0);
            chk("err", 32'(flash_error), 32'h1);
            chk("irq", 32'(irq), 32'h1);
            rd(FC2_OFS, v);
            chk("fc2", v, 32'h80);
            rd(STAT_OFS, v);
            chk("stat", v, 32'h4);
            start(PRG);
            chk("prog", 32'(flash_prog), 32'h0);
            lp <= 3'h4;
            tick(2);
            lp <= 3'h0;
            chk("err", 32'(flash_error), 32'h1);
        end
        end_of_test();
    end
endmodule
